// ### include/gicp_map.svh
`ifndef GICP_MAP_SVH
`define GICP_MAP_SVH
// Operation
// [R01] Device answers only to fixed seven-bit target address 1010101.
// [R02] Host sends address byte 0xAA for write, 0xAB for read.
// [R03] Supports plain, incremental and quick reads, one-byte and incremental writes.
// [R04] Quick read returns byte at current internal address pointer.
// [R05] Pointer advances by one on every acknowledged data byte, either side.
// [R06] Written data bytes land in consecutive command locations.
// [R07] Data written to a read-only location is not acknowledged.
// [R08] Command byte above 0x6B is not acknowledged.
// [R09] Location 0x6A reports last used profile in bit0, upper bits zero.
// [R10] Bus held low for timeout count times half second releases both lines.
// [R11] Host waits 100 ms after checksum, 1.2 s after OCV subcommand.
// [R12] Host polls full standard command set at most twice per second.
// [R13] Device may stretch clock 80 ms or 270 ms; host tolerates it. The host model flags a stall after 2000 clock cycles of stretch.
// [R14] Foreign target address is ignored and never acknowledged.

`define GICP_TARGET_ADDR 7'h55
`define GICP_CMD_MAX 8'h6B
`define GICP_PROFILE_STATUS 8'h6A
`define GICP_PROFILE_BIT 0
`define GICP_PROFILE_RESET 1'b0
`define GICP_CLK_HZ 25000000
`define GICP_HALF_SEC_MS 500
`define GICP_HALF_SEC_CYC ((`GICP_CLK_HZ / 1000) * `GICP_HALF_SEC_MS)
`define GICP_LOC_COUNT 128
`endif

// ### include/gicp_pkg.sv
package gicp_pkg;
    typedef enum logic [3:0] {
        GICP_IDLE, GICP_ADDR, GICP_ADDR_ACK, GICP_CMD, GICP_CMD_ACK,
        GICP_WDATA, GICP_WDATA_ACK, GICP_RDATA, GICP_RDATA_ACK
    } gicp_phase_e;
    typedef logic [7:0] gicp_byte_t;
endpackage

// ### core/gicp_line_watch.sv
`timescale 1ns/1ps
`include "gicp_map.svh"
// Counts half-second ticks while a bus line sits low
module gicp_line_watch (
    input wire logic clock,            // System clock
    input wire logic rst_n,            // Synchronised reset
    input wire logic line_low,         // Either bus line low
    input wire logic [7:0] limit,      // Timeout in half seconds, zero disables
    output logic expired               // Bus stuck low too long
);
    parameter int unsigned HALF_SEC_CYC = `GICP_HALF_SEC_CYC;
    typedef struct packed {
        logic [24:0] div;
        logic [7:0] ticks;
        logic expired;
    } gicp_watch_s;
    gicp_watch_s st, next_st;

    always_comb begin
        next_st = st;
        if (!line_low) begin
            next_st = '0;
        end else if (limit != 8'h00 && !st.expired) begin
            if (st.div == 25'(HALF_SEC_CYC - 1)) begin
                next_st.div = '0;
                next_st.ticks = st.ticks + 8'h01;
                if (st.ticks + 8'h01 == limit) begin
                    next_st.expired = 1'b1; // [R10]
                end
            end else begin
                next_st.div = st.div + 25'h0000001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.expired;
endmodule

// ### core/gicp_target.sv
`timescale 1ns/1ps
`include "gicp_map.svh"
module gicp_target
    import gicp_pkg::*;
(
    input wire logic clock,                  // 25 MHz system clock
    input wire logic rstn,                   // Async reset, active low
    input wire logic scl_i,                  // Serial clock level
    input wire logic sda_i,                  // Serial data level
    output logic sda_o,                      // Always low when driven
    output logic sda_oe,                     // High while pulling data low
    output logic scl_o,                      // Always low when driven
    output logic scl_oe,                     // High while stretching clock
    input wire logic stretch_req,            // Core asks for a clock stretch
    input wire logic [7:0] timeout_limit,    // Stuck-bus timeout, half seconds
    input wire logic last_used_profile_bit,  // Profile in use, from core
    input wire logic [127:0] read_only_map,  // One bit per read-only location
    input wire logic [7:0] core_rdata,       // Core data at wr/rd pointer
    output gicp_pkg::gicp_byte_t loc_addr,   // Current pointer
    output gicp_pkg::gicp_byte_t wr_data,    // Byte being written
    output logic wr_strobe,                  // One-cycle write pulse
    output logic bus_released                // Timeout hold-off active
);
    import gicp_pkg::*;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic scl_d;
        logic sda_d;
        gicp_phase_e phase;
        logic [3:0] bits;
        gicp_byte_t shreg;
        gicp_byte_t ptr;
        logic rd_dir;
        logic drive_low;
        gicp_byte_t wdata;
        logic wstb;
        logic profile;
    } gicp_state_s;

    gicp_state_s st, next_st;
    logic rst_n;
    logic expired;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    gicp_byte_t rd_byte;

    assign rst_n = st.rst_sync[1];
    assign scl_rise = scl_i && !st.scl_d;
    assign scl_fall = !scl_i && st.scl_d;
    assign start_cond = st.scl_d && scl_i && st.sda_d && !sda_i;
    assign stop_cond = st.scl_d && scl_i && !st.sda_d && sda_i;

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always_comb begin
        if (st.ptr == `GICP_PROFILE_STATUS) begin
            rd_byte = {7'h00, st.profile}; // [R09]
        end else begin
            rd_byte = core_rdata;
        end
    end

    gicp_line_watch i_gicp_line_watch (
        .clock(clock),
        .rst_n(rst_n),
        .line_low(!scl_i || !sda_i),
        .limit(timeout_limit),
        .expired(expired)
    );

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        next_st.scl_d = scl_i;
        next_st.sda_d = sda_i;
        next_st.wstb = 1'b0;
        next_st.profile = last_used_profile_bit;
        if (expired) begin
            next_st.phase = GICP_IDLE; // [R10]
            next_st.drive_low = 1'b0;
        end else if (start_cond) begin
            // Repeated start keeps the pointer for combined reads
            next_st.phase = GICP_ADDR;
            next_st.bits = 4'h0;
            next_st.drive_low = 1'b0;
        end else if (stop_cond) begin
            next_st.phase = GICP_IDLE;
            next_st.drive_low = 1'b0;
        end else begin
            unique case (st.phase)
                GICP_IDLE: begin
                end
                GICP_ADDR, GICP_CMD, GICP_WDATA: begin
                    if (scl_rise) begin
                        next_st.shreg = {st.shreg[6:0], sda_i};
                        next_st.bits = st.bits + 4'h1;
                    end else if (scl_fall && st.bits == 4'h8) begin
                        next_st.bits = 4'h0;
                        if (st.phase == GICP_ADDR) begin
                            if (st.shreg[7:1] == `GICP_TARGET_ADDR) begin // [R01] [R02]
                                next_st.rd_dir = st.shreg[0];
                                next_st.drive_low = 1'b1;
                                next_st.phase = GICP_ADDR_ACK;
                            end else begin
                                next_st.phase = GICP_IDLE; // [R14]
                            end
                        end else if (st.phase == GICP_CMD) begin
                            next_st.ptr = st.shreg;
                            next_st.drive_low = (st.shreg <= `GICP_CMD_MAX); // [R08]
                            next_st.phase = GICP_CMD_ACK;
                        end else begin
                            // [R07] read-only or out-of-range data is refused
                            if (st.ptr[7] == 1'b0 && !read_only_map[st.ptr[6:0]]) begin
                                next_st.drive_low = 1'b1;
                                next_st.wdata = st.shreg;
                                next_st.wstb = 1'b1; // [R06]
                            end
                            next_st.phase = GICP_WDATA_ACK;
                        end
                    end
                end
                GICP_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (st.rd_dir) begin
                            next_st.shreg = rd_byte; // [R04] [R03]
                            next_st.drive_low = !rd_byte[7];
                            next_st.bits = 4'h0;
                            next_st.phase = GICP_RDATA;
                        end else begin
                            next_st.drive_low = 1'b0;
                            next_st.phase = GICP_CMD;
                        end
                    end
                end
                GICP_CMD_ACK: begin
                    if (scl_fall) begin
                        next_st.phase = st.drive_low ? GICP_WDATA : GICP_IDLE;
                        next_st.drive_low = 1'b0;
                    end
                end
                GICP_WDATA_ACK: begin
                    if (scl_fall) begin
                        if (st.drive_low) begin
                            next_st.ptr = st.ptr + 8'h01; // [R05]
                            next_st.phase = GICP_WDATA;
                        end else begin
                            next_st.phase = GICP_IDLE;
                        end
                        next_st.drive_low = 1'b0;
                    end
                end
                GICP_RDATA: begin
                    if (scl_fall) begin
                        if (st.bits == 4'h7) begin
                            next_st.drive_low = 1'b0;
                            next_st.phase = GICP_RDATA_ACK;
                        end else begin
                            next_st.shreg = {st.shreg[6:0], 1'b0};
                            next_st.drive_low = !st.shreg[6];
                            next_st.bits = st.bits + 4'h1;
                        end
                    end
                end
                GICP_RDATA_ACK: begin
                    if (scl_rise) begin
                        if (!sda_i) begin
                            next_st.ptr = st.ptr + 8'h01; // [R05]
                            next_st.phase = GICP_RDATA_ACK;
                            next_st.rd_dir = 1'b1;
                        end else begin
                            next_st.phase = GICP_IDLE;
                        end
                    end else if (scl_fall) begin
                        next_st.shreg = rd_byte;
                        next_st.drive_low = !rd_byte[7];
                        next_st.bits = 4'h0;
                        next_st.phase = GICP_RDATA; // [R03] incremental read
                    end
                end
                default: begin
                    next_st.phase = GICP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '{rst_sync: 2'b00, scl_d: 1'b1, sda_d: 1'b1, phase: GICP_IDLE,
                    bits: 4'h0, shreg: 8'h00, ptr: 8'h00, rd_dir: 1'b0,
                    drive_low: 1'b0, wdata: 8'h00, wstb: 1'b0,
                    profile: `GICP_PROFILE_RESET};
        end else if (!st.rst_sync[1]) begin
            st.rst_sync <= next_st.rst_sync;
        end else begin
            st <= next_st;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = st.drive_low && !expired;
    assign scl_o = 1'b0;
    // Stretch only a clock the host already pulled low, never cut a high phase
    assign scl_oe = stretch_req && !expired && st.phase != GICP_IDLE && !st.scl_d; // [R13]
    assign loc_addr = st.ptr;
    assign wr_data = st.wdata;
    assign wr_strobe = st.wstb;
    assign bus_released = expired;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_cmd_range: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
        (st.phase == GICP_CMD && scl_fall && st.bits == 4'h8 && st.shreg > `GICP_CMD_MAX
         && !start_cond && !stop_cond && !expired) |=> !sda_oe)
        else $error("command above limit was acknowledged");
    a_addr_match: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
        (st.phase == GICP_ADDR && scl_fall && st.bits == 4'h8
         && st.shreg[7:1] != `GICP_TARGET_ADDR && !start_cond && !stop_cond)
         |=> st.phase == GICP_IDLE && !sda_oe)
        else $error("foreign address not ignored");
    a_addr_ack: assert property (@(posedge clock) disable iff (!rst_n) // [R01]
        (st.phase == GICP_ADDR && scl_fall && st.bits == 4'h8 && !expired
         && st.shreg[7:1] == `GICP_TARGET_ADDR && !start_cond && !stop_cond) |=> sda_oe)
        else $error("own address not acknowledged");
    a_ro_nack: assert property (@(posedge clock) disable iff (!rst_n) // [R07]
        (st.phase == GICP_WDATA && scl_fall && st.bits == 4'h8 && !st.ptr[7]
         && read_only_map[st.ptr[6:0]]) |=> !wr_strobe && !sda_oe)
        else $error("read-only write accepted");
    a_ptr_step: assert property (@(posedge clock) disable iff (!rst_n) // [R05]
        (st.phase == GICP_WDATA_ACK && scl_fall && st.drive_low && !expired
         && !start_cond && !stop_cond) |=> st.ptr == $past(st.ptr) + 8'h01)
        else $error("pointer did not advance");
    a_wr_store: assert property (@(posedge clock) disable iff (!rst_n) // [R06]
        wr_strobe |-> st.phase == GICP_WDATA_ACK && st.drive_low && !loc_addr[7]
                      && !read_only_map[loc_addr[6:0]])
        else $error("write pulse without accepted data byte");
    a_profile_rd: assert property (@(posedge clock) disable iff (!rst_n) // [R09]
        st.ptr == `GICP_PROFILE_STATUS
        |-> rd_byte[7:1] == 7'h00 && rd_byte[0] == $past(last_used_profile_bit))
        else $error("profile status byte wrong");
    a_release: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
        expired |-> !sda_oe && !scl_oe)
        else $error("lines held after timeout");
    c_write: cover property (@(posedge clock) disable iff (!rst_n) wr_strobe);
    c_read: cover property (@(posedge clock) disable iff (!rst_n)
        st.phase == GICP_RDATA_ACK && scl_rise && !sda_i);
    c_timeout: cover property (@(posedge clock) disable iff (!rst_n) expired);
    c_stretch: cover property (@(posedge clock) disable iff (!rst_n) scl_oe && !scl_i);
endmodule

// ### test/gicp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus controller model, open-drain outputs
// ----------------------------------------
module gicp_host_model (
    input wire logic clock,   // System clock
    input wire logic scl,     // Resolved clock line
    input wire logic sda,     // Resolved data line
    output logic scl_low,     // High pulls clock low
    output logic sda_low,     // High pulls data low
    output logic stall        // Clock stretch ran too long
);
    localparam int HALF = 8;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        stall = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic rise_wait();
        int n;
        n = 0;
        scl_low <= 1'b0;
        tick(1);
        while (!scl && n < 2000) begin // Target may hold clock low
            tick(1);
            n++;
        end
        if (!scl) stall <= 1'b1;
        tick(HALF);
    endtask
    task automatic bit_io(input logic b, output logic got);
        sda_low <= !b;
        tick(HALF);
        rise_wait();
        got = sda;
        scl_low <= 1'b1;
        tick(HALF);
    endtask
    // Doubles as repeated start from a low clock
    task automatic start();
        sda_low <= 1'b0;
        tick(HALF);
        rise_wait();
        sda_low <= 1'b1;
        tick(HALF);
        scl_low <= 1'b1;
        tick(HALF);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick(HALF);
        rise_wait();
        sda_low <= 1'b0;
        tick(HALF);
    endtask
    // Address byte carries direction in bit 0
    task automatic wbyte(input logic [7:0] b, output logic nack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(b[i], g);
        bit_io(1'b1, nack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, g);
    endtask
endmodule

// ### test/gauge_i2c_command_port_bench.sv
`timescale 1ns/1ps
module gauge_i2c_command_port_bench;
    import gicp_pkg::*;
    logic clock, rstn, stretch_req, last_used_profile_bit;
    logic [7:0] timeout_limit, core_rdata;
    logic [127:0] read_only_map;
    logic sda_o, sda_oe, scl_o, scl_oe, wr_strobe, bus_released;
    logic h_scl_low, h_sda_low, h_stall;
    gicp_byte_t loc_addr, wr_data;
    logic [7:0] mem [128];
    int error_cnt, n_tests, cyc;
    wire scl_w, sda_w;
    // Pull-ups hold both lines high unless someone pulls
    assign scl_w = !(h_scl_low || scl_oe);
    assign sda_w = !(h_sda_low || sda_oe);
    assign core_rdata = mem[loc_addr[6:0]];
    gicp_target i_gicp_target (.clock(clock), .rstn(rstn), .scl_i(scl_w), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
        .stretch_req(stretch_req), .timeout_limit(timeout_limit),
        .last_used_profile_bit(last_used_profile_bit), .read_only_map(read_only_map),
        .core_rdata(core_rdata), .loc_addr(loc_addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .bus_released(bus_released));
    gicp_host_model i_gicp_host_model (.clock(clock), .scl(scl_w), .sda(sda_w),
        .scl_low(h_scl_low), .sda_low(h_sda_low), .stall(h_stall));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        if (wr_strobe === 1'b1) mem[loc_addr[6:0]] <= wr_data;
    end
    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Whole run needs about 9k cycles; generous ceiling
    always @(posedge clock) begin
        cyc++;
        if (cyc >= 40000 || h_stall === 1'b1) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_nack);
        logic a;
        i_gicp_host_model.wbyte(b, a);
        check({7'h00, a}, {7'h00, exp_nack});
    endtask
    task automatic recv(input logic nack, input logic [7:0] exp);
        logic [7:0] v;
        i_gicp_host_model.rbyte(nack, v);
        check(v, exp);
    endtask
    task automatic s();
        i_gicp_host_model.start();
    endtask
    task automatic p();
        i_gicp_host_model.stop();
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    // Only plain commands, no subcommands, far below the polling limit
    initial begin
        rstn = 1'b0;
        stretch_req = 1'b0;
        timeout_limit = 8'h00;
        last_used_profile_bit = 1'b0;
        read_only_map = '0;
        read_only_map[8'h10] = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        for (int i = 0; i < 128; i++) mem[i] = 8'h00;
        mem[8'h41] = 8'hC3;
        mem[8'h00] = 8'h5A;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        s();
        send(8'hAA, 1'b0);
        send(8'h20, 1'b0);
        send(8'h11, 1'b0);
        send(8'h22, 1'b0);
        p();
        check(mem[8'h20], 8'h11);
        check(mem[8'h21], 8'h22);
        $display("incremental write done");
        s();
        send(8'hAA, 1'b0);
        send(8'h20, 1'b0);
        s();
        send(8'hAB, 1'b0);
        recv(1'b0, 8'h11);
        recv(1'b1, 8'h22);
        p();
        $display("incremental read done");
        s();
        send(8'hAA, 1'b0);
        send(8'h40, 1'b0);
        send(8'h77, 1'b0);
        p();
        s();
        send(8'hAB, 1'b0);
        recv(1'b1, 8'hC3);
        p();
        $display("quick read done");
        s();
        send(8'hAA, 1'b0);
        send(8'h10, 1'b0);
        send(8'h99, 1'b1);
        p();
        check(mem[8'h10], 8'h00);
        $display("read-only write done");
        for (int c = 8'h6B; c <= 8'h6C; c++) begin
            s();
            send(8'hAA, 1'b0);
            send(c[7:0], c > 8'h6B);
            p();
        end
        $display("command range done");
        for (int k = 0; k < 2; k++) begin
            last_used_profile_bit <= k[0];
            s();
            send(8'hAA, 1'b0);
            send(8'h6A, 1'b0);
            s();
            send(8'hAB, 1'b0);
            recv(1'b1, {7'h00, k[0]});
            p();
        end
        $display("profile status done");
        s();
        send(8'hAC, 1'b1);
        p();
        s();
        send(8'hAA, 1'b0);
        p();
        $display("foreign address done");
        stretch_req <= 1'b1;
        s();
        fork
            send(8'hAA, 1'b0);
            begin
                repeat (100) @(posedge clock);
                check({6'h00, scl_oe, scl_w}, 8'h02);
                check({5'h00, bus_released, sda_o, scl_o}, 8'h00);
                stretch_req <= 1'b0;
            end
        join
        p();
        $display("clock stretch done");
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        s();
        send(8'hAB, 1'b0);
        recv(1'b1, 8'h5A);
        p();
        $display("mid-run reset done");
        close_out();
    end
endmodule
